// >>> design/bld_lane_status.sv
/*
 * Byte-lane decode and bus status outputs for a backplane bus controller.
 * Assumes the local board feeds inverted low address bits and the bus side
 * lines arrive asynchronously; all are synchronised to clk_sys first.
 * Outputs follow the pins three clk_sys edges later, so a pin pulse shorter
 * than one clock may be lost; the clock copies are sampled, not passed
 * through, and carry the same lag.
 */
//
// Overview of operation
// - Classify transfer as byte, halfword, word or block from address and mode.
// - Four active-low lane enables decoded from low address and TM0 only.
// - TM1 selects read or write only; lane enables ignore it.
// - Master-done asserts when local board is master and acknowledge is received.
// - Master-done stays set until the master-hold input is released or bus reset goes active.
// - Acknowledge monitor output is an inverted buffered acknowledge.
// - One clock copy output is the inverted bus clock.
// - Another clock copy output is the true bus clock.
// - TM0 low selects lane n; TM0 high gives word, halfwords or block.
`timescale 1ns/1ps
module bld_lane_status (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// Local board inputs
	input  wire logic [1:0]        addrLowInvN,
	input  wire logic              master_status_hold_n,
	input  wire logic              masterOwned,
	// Bus inputs
	input  wire logic              transferMode0,
	input  wire logic              transferMode1,
	input  wire logic              busAck,
	input  wire logic              busClock,
	input  wire logic              busResetN,
	// Lane enables, direction and transfer class
	output logic                   lane0_enable_n,
	output logic                   lane1_enable_n,
	output logic                   lane2_enable_n,
	output logic                   lane3_enable_n,
	output logic                   cycleRead,
	output bld_pkg::bld_xfer_t     transferClass,
	// Status
	output logic                   master_cycle_complete,
	output logic                   acknowledge_monitor_n,
	output logic                   bus_clock_copy,
	output logic                   busClockTrue
);
	import bld_pkg::*;

	// Position of each pin inside the synchroniser vector.
	localparam int POS_ADDR_LO = 7;
	localparam int POS_ADDR_HI = 8;
	localparam int POS_MODE0   = 6;
	localparam int POS_MODE1   = 5;
	localparam int POS_ACK     = 4;
	localparam int POS_BUSCLK  = 3;
	localparam int POS_MASTER  = 2;
	localparam int POS_HOLD    = 1;
	localparam int POS_BUSRST  = 0;
	localparam int PIN_COUNT   = 9;

	// Output levels held during reset.
	localparam logic READ_RST     = 1'b0;
	localparam logic ACK_MON_RST  = 1'b1;
	localparam logic CLK_INV_RST  = 1'b1;
	localparam logic CLK_TRUE_RST = 1'b0;

	bld_sync_if syncBus ();
	logic [PIN_COUNT-1:0] syncVec;

	bld_sync #(
		.WIDTH(PIN_COUNT)
	) uSync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pinIn   ({addrLowInvN, transferMode0, transferMode1, busAck, busClock,
		            masterOwned, master_status_hold_n, busResetN}),
		.syncOut (syncVec)
	);

	// The address pins already carry the inverted bus lines, so they index lanes directly.
	// Bus reset and hold keep their active-low sense through the synchroniser.
	assign syncBus.addrLow   = syncVec[POS_ADDR_HI:POS_ADDR_LO];
	assign syncBus.modeLane  = syncVec[POS_MODE0];
	assign syncBus.modeRead  = syncVec[POS_MODE1];
	assign syncBus.ackLevel  = syncVec[POS_ACK];
	assign syncBus.busClk    = syncVec[POS_BUSCLK];
	assign syncBus.masterWon = syncVec[POS_MASTER];
	assign syncBus.holdN     = syncVec[POS_HOLD];
	assign syncBus.busResetN = syncVec[POS_BUSRST];

	logic [3:0]      lanes_reg;
	logic [3:0]      lanes_next;
	bld_xfer_t       class_reg;
	bld_xfer_t       class_next;
	logic            read_reg;
	logic            read_next;
	bld_done_state_t done_reg;
	bld_done_state_t done_next;
	logic            ackMon_reg;
	logic            ackMon_next;
	logic            clkInv_reg;
	logic            clkInv_next;
	logic            clkTrue_reg;
	logic            clkTrue_next;

	// Lane decode uses only the address and TM0; TM1 never reaches it.
	always_comb begin
		lanes_next = LANE_NONE_N;
		if (!syncBus.modeLane) begin
			lanes_next[syncBus.addrLow] = 1'b0;
		end else begin
			unique case (syncBus.addrLow)
				ADDR_0: lanes_next = LANE_ALL_N;
				ADDR_1: lanes_next = LANE_HALF0_N;
				ADDR_2: lanes_next = LANE_ALL_N;
				ADDR_3: lanes_next = LANE_HALF1_N;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lanes_reg <= LANE_NONE_N;
		end else begin
			lanes_reg <= lanes_next;
		end
	end

	// Class and direction sit in their own group, so a TM1 change can only move cycleRead.
	always_comb begin
		class_next = XFER_BYTE;
		if (syncBus.modeLane) begin
			unique case (syncBus.addrLow)
				ADDR_0: class_next = XFER_WORD;
				ADDR_1: class_next = XFER_HALF;
				ADDR_2: class_next = XFER_BLOCK;
				ADDR_3: class_next = XFER_HALF;
			endcase
		end else begin
			class_next = XFER_BYTE;
		end
		read_next = syncBus.modeRead;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			class_reg <= XFER_BYTE;
			read_reg  <= READ_RST;
		end else begin
			class_reg <= class_next;
			read_reg  <= read_next;
		end
	end

	// Hold is active low: a held flag survives any number of acknowledges until release.
	always_comb begin
		done_next = done_reg;
		unique case (done_reg)
			DONE_IDLE: begin
				if (syncBus.masterWon && syncBus.ackLevel) begin
					done_next = DONE_HELD;
				end
			end
			DONE_HELD: begin
				if (syncBus.holdN) begin
					done_next = DONE_IDLE;
				end
			end
		endcase
		if (!syncBus.busResetN) begin
			done_next = DONE_IDLE;
		end
	end

	// The synchroniser wakes with zeros, so the bus reset reads active after a system
	// reset and done stays low until real pin levels have arrived.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			done_reg <= DONE_IDLE;
		end else begin
			done_reg <= done_next;
		end
	end

	// Clock copies pass through the synchroniser, so they lag the bus clock by about three cycles.
	always_comb begin
		ackMon_next  = ~syncBus.ackLevel;
		clkInv_next  = ~syncBus.busClk;
		clkTrue_next = syncBus.busClk;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ackMon_reg  <= ACK_MON_RST;
			clkInv_reg  <= CLK_INV_RST;
			clkTrue_reg <= CLK_TRUE_RST;
		end else begin
			ackMon_reg  <= ackMon_next;
			clkInv_reg  <= clkInv_next;
			clkTrue_reg <= clkTrue_next;
		end
	end

	assign lane0_enable_n        = lanes_reg[0];
	assign lane1_enable_n        = lanes_reg[1];
	assign lane2_enable_n        = lanes_reg[2];
	assign lane3_enable_n        = lanes_reg[3];
	assign transferClass         = class_reg;
	assign cycleRead             = read_reg;

	// The done state is a single flop, so the flag is that flop's bit.
	assign master_cycle_complete = (done_reg == DONE_HELD);
	assign acknowledge_monitor_n = ackMon_reg;
	assign bus_clock_copy        = clkInv_reg;
	assign busClockTrue          = clkTrue_reg;

endmodule // bld_lane_status

// >>> design/bld_pkg.sv
/*
 * Package for the byte-lane decode and bus status block: lane codes,
 * transfer classes and synchroniser depth.
 * Assumes a single system clock domain; all bus pins are asynchronous to it.
 */
package bld_pkg;

	localparam int LANES      = 4;
	localparam int SYNC_STAGES = 2;

	// Active-low lane enable patterns, bit n is lane n.
	localparam logic [3:0] LANE_ALL_N   = 4'h0;
	localparam logic [3:0] LANE_NONE_N  = 4'hF;
	localparam logic [3:0] LANE_HALF0_N = 4'hC;
	localparam logic [3:0] LANE_HALF1_N = 4'h3;

	// Low address codes as seen by the decode.
	localparam logic [1:0] ADDR_0 = 2'h0;
	localparam logic [1:0] ADDR_1 = 2'h1;
	localparam logic [1:0] ADDR_2 = 2'h2;
	localparam logic [1:0] ADDR_3 = 2'h3;

	typedef enum logic [2:0] {
		XFER_BYTE,
		XFER_HALF,
		XFER_WORD,
		XFER_BLOCK
	} bld_xfer_t;

	typedef enum logic {
		DONE_IDLE,
		DONE_HELD
	} bld_done_state_t;

endpackage

// >>> design/bld_sync.sv
/*
 * Two-stage synchroniser bank for every asynchronous input of the block.
 * Assumes the pins are asynchronous to clk_sys; the first stage feeds only
 * the second.
 */
`timescale 1ns/1ps
module bld_sync #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Raw pins
	input  wire logic [WIDTH-1:0] pinIn,
	// Synchronised levels
	output logic      [WIDTH-1:0] syncOut
);
	import bld_pkg::*;

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage2_next;

	always_comb begin
		stage1_next = pinIn;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign syncOut = stage2_reg;

endmodule // bld_sync

// >>> design/bld_sync_if.sv
/*
 * Interface carrying synchronised pin levels from the input stage to the
 * decode and status logic.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface bld_sync_if;
	logic [1:0] addrLow;
	logic       modeLane;
	logic       modeRead;
	logic       ackLevel;
	logic       busClk;
	logic       masterWon;
	logic       holdN;
	logic       busResetN;

	modport producer (output addrLow, modeLane, modeRead, ackLevel, busClk, masterWon, holdN, busResetN);
	modport consumer (input addrLow, modeLane, modeRead, ackLevel, busClk, masterWon, holdN, busResetN);
endinterface

// >>> sim/bld_lane_status_asserts.sv
/* Port checker for bld_lane_status.
   Assumes one clock domain and outputs three edges behind the pins. */
`timescale 1ns/1ps
module bld_lane_status_asserts (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Inputs
	input wire logic [1:0] addrLowInvN,
	input wire logic       master_status_hold_n,
	input wire logic       masterOwned,
	input wire logic       transferMode0,
	input wire logic       transferMode1,
	input wire logic       busAck,
	input wire logic       busClock,
	input wire logic       busResetN,
	// Outputs
	input wire logic       lane0_enable_n,
	input wire logic       lane1_enable_n,
	input wire logic       lane2_enable_n,
	input wire logic       lane3_enable_n,
	input wire logic       cycleRead,
	input wire logic       master_cycle_complete,
	input wire logic       acknowledge_monitor_n,
	input wire logic       bus_clock_copy,
	input wire logic       busClockTrue
);
	logic [2:0] warm_reg;
	logic [2:0] warm_next;
	logic       ok;
	// Synchroniser still holds reset zeros for the first edges, so checks wait.
	always_comb warm_next = (warm_reg == 3'h4) ? warm_reg : warm_reg + 3'h1;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			warm_reg <= 3'h0;
		end else begin
			warm_reg <= warm_next;
		end
	end
	assign ok = warm_reg > 3'h2;
	function automatic logic [3:0] lanesOf(input logic [1:0] a, input logic m);
		return m ? (a[0] ? (a[1] ? 4'h3 : 4'hC) : 4'h0) : ~(4'h1 << a);
	endfunction
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_granted;
		!master_cycle_complete && $past(masterOwned, 2) && $past(busAck, 2) && $past(busResetN, 2);
	endsequence
	sequence s_holding;
		master_cycle_complete && !$past(master_status_hold_n, 2) && $past(busResetN, 2);
	endsequence
	a_ack_inverse: assert property (ok |-> acknowledge_monitor_n == !$past(busAck, 3))
		else $error("ack monitor mismatch");
	a_clock_inverse: assert property (ok |-> bus_clock_copy == !$past(busClock, 3))
		else $error("inverted clock copy mismatch");
	a_clock_true: assert property (ok |-> busClockTrue == $past(busClock, 3))
		else $error("true clock copy mismatch");
	a_lane_decode: assert property (ok |-> {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n}
		== lanesOf($past(addrLowInvN, 3), $past(transferMode0, 3))) else $error("lane enables mismatch");
	a_read_mode: assert property (ok |-> cycleRead == $past(transferMode1, 3))
		else $error("read flag mismatch");
	a_done_set: assert property (ok ##0 s_granted |=> master_cycle_complete)
		else $error("done not set");
	a_done_keep: assert property (ok ##0 s_holding |=> master_cycle_complete)
		else $error("done dropped while held");
	a_done_clear: assert property (ok && master_cycle_complete && $past(master_status_hold_n, 2) |=>
		!master_cycle_complete) else $error("done not cleared");
	a_reset_done: assert property (ok && !$past(busResetN, 3) |-> !master_cycle_complete)
		else $error("done set in bus reset");
endmodule // bld_lane_status_asserts
bind bld_lane_status bld_lane_status_asserts chk (
	.clk_sys               (clk_sys),
	.resetn                (resetn),
	.addrLowInvN           (addrLowInvN),
	.master_status_hold_n  (master_status_hold_n),
	.masterOwned           (masterOwned),
	.transferMode0         (transferMode0),
	.transferMode1         (transferMode1),
	.busAck                (busAck),
	.busClock              (busClock),
	.busResetN             (busResetN),
	.lane0_enable_n        (lane0_enable_n),
	.lane1_enable_n        (lane1_enable_n),
	.lane2_enable_n        (lane2_enable_n),
	.lane3_enable_n        (lane3_enable_n),
	.cycleRead             (cycleRead),
	.master_cycle_complete (master_cycle_complete),
	.acknowledge_monitor_n (acknowledge_monitor_n),
	.bus_clock_copy        (bus_clock_copy),
	.busClockTrue          (busClockTrue)
);

// >>> sim/bld_local_board.sv
/* Local board model in front of the controller.
   Assumes the bus address lines arrive active low from the backplane. */
`timescale 1ns/1ps
module bld_local_board (
	// Bus side
	input  wire logic [1:0] busAddrN,
	input  wire logic       holdReq,
	// Controller side
	output logic      [1:0] addrLowInvN,
	output logic            master_status_hold_n
);
	// The buffer inverts the active-low lines, so the controller sees true values.
	assign addrLowInvN = ~busAddrN;
	assign master_status_hold_n = ~holdReq;
endmodule // bld_local_board

// >>> sim/test_bld_lane_status.sv
/* Self-checking bench for bld_lane_status with a local board model.
   Assumes a three-edge output latency from every input pin. */
`timescale 1ns/1ps
module test_bld_lane_status;
	import bld_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, holdReq = 1'b0, masterOwned = 1'b0, transferMode0 = 1'b0;
	logic transferMode1 = 1'b0, busAck = 1'b0, busClock = 1'b0, busResetN = 1'b1;
	logic [1:0] busAddrN = 2'h0, addrLowInvN;
	logic master_status_hold_n, lane0_enable_n, lane1_enable_n, lane2_enable_n, lane3_enable_n;
	logic cycleRead, master_cycle_complete, acknowledge_monitor_n, bus_clock_copy, busClockTrue;
	bld_xfer_t transferClass;
	logic [8:0] q[$];
	logic [8:0] v;
	logic [11:0] seen, want;
	logic doneM = 1'b0;
	int failures = 0, n_checks = 0;
	always #2 clk_sys = ~clk_sys;
	bld_local_board board (.busAddrN(busAddrN), .holdReq(holdReq), .addrLowInvN(addrLowInvN),
		.master_status_hold_n(master_status_hold_n));
	bld_lane_status dut (
		.clk_sys               (clk_sys),
		.resetn                (resetn),
		.addrLowInvN           (addrLowInvN),
		.master_status_hold_n  (master_status_hold_n),
		.masterOwned           (masterOwned),
		.transferMode0         (transferMode0),
		.transferMode1         (transferMode1),
		.busAck                (busAck),
		.busClock              (busClock),
		.busResetN             (busResetN),
		.lane0_enable_n        (lane0_enable_n),
		.lane1_enable_n        (lane1_enable_n),
		.lane2_enable_n        (lane2_enable_n),
		.lane3_enable_n        (lane3_enable_n),
		.cycleRead             (cycleRead),
		.transferClass         (transferClass),
		.master_cycle_complete (master_cycle_complete),
		.acknowledge_monitor_n (acknowledge_monitor_n),
		.bus_clock_copy        (bus_clock_copy),
		.busClockTrue          (busClockTrue)
	);
	assign seen = {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n, cycleRead, transferClass,
		master_cycle_complete, acknowledge_monitor_n, bus_clock_copy, busClockTrue};
	function automatic logic [11:0] exp_of(input logic [8:0] x, input logic d);
		logic [2:0] c;
		c = !x[2] ? XFER_BYTE : x[0] ? XFER_HALF : x[1] ? XFER_BLOCK : XFER_WORD;
		return {x[2] ? (x[0] ? (x[1] ? 4'h3 : 4'hC) : 4'h0) : ~(4'h1 << x[1:0]), x[3], c, d, ~x[4], ~x[5], x[5]};
	endfunction
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#40000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(67289));
		repeat (6) @(posedge clk_sys);
		#1 resetn = 1'b1;
		q = '{9'h0, 9'h0};
		repeat (3000) begin
			@(posedge clk_sys);
			q.push_back({busResetN, master_status_hold_n, masterOwned, busClock, busAck, transferMode1,
				transferMode0, addrLowInvN});
			v = q[$-2];
			// A release of the hold wins over a fresh acknowledge; the set comes one cycle later.
			doneM = !v[8] ? 1'b0 : doneM ? !v[7] : v[6] & v[4];
			#1 {busAddrN, holdReq, masterOwned, transferMode0, transferMode1, busAck, busClock} = 8'($urandom);
			busResetN = ($urandom % 16) != 0;
			@(negedge clk_sys);
			want = exp_of(v, doneM);
			n_checks++;
			if (seen !== want) begin
				failures++;
				$display("[FAIL] outputs expected %h seen %h", want, seen);
			end
		end
		summarize();
	end
endmodule // test_bld_lane_status
